// ### hw/epiu_consts.svh
// Notes on behaviour
// - group 2 covers inputs 23..16, group 1 inputs 14..8, group 0 inputs 7..0
// - requests trigger from pin activity even when pins are driven as outputs
// - pin-change detection must not depend on the i/o clock running
// - level sense keeps requesting while the enabled pin stays low
// - edge detection is clocked; stopped i/o clock means edges are missed
// - low-level detection is asynchronous so it can wake the part
// - level gone before start-up ends: wake happens, no request is raised
// - request-1 sense bits 3:2: 00 low, 01 change, 10 fall, 11 rise
// - request-0 sense bits 1:0 use the same encoding
// - pins are sampled before edge detection; pulses over one clock are caught
// - enable bits 1 and 0 gate requests together with the global bit
// - each dedicated request has its own vector
// - flag bit sets when an edge or change on its pin triggers a request
// - flag clears on routine entry or on writing one; zero leaves it
// - flag is held cleared while its pin is in level sense
// - group enable bits 2..0 gate groups together with the global bit
// - each pin-change group has its own vector
// - per-group masks select which pins contribute
// - unused upper bits of sense, enable, flag and group registers read zero
// - group flag sets on a triggering change; clears on entry or writing one
// - a pin counts only when its mask bit and group enable are both one
`ifndef EPIU_CONSTS_SVH
`define EPIU_CONSTS_SVH

// ----------------------------------------
// register indices; byte address is four times the index
// ----------------------------------------
`define EPIU_IDX_ENABLE     7'h3d
`define EPIU_IDX_SENSE      7'h69
`define EPIU_IDX_MASK0      7'h6b
`define EPIU_IDX_MASK1      7'h6c
`define EPIU_IDX_MASK2      7'h6d
// unprinted indices, arbitrary free slots
`define EPIU_IDX_FLAGS      7'h70
`define EPIU_IDX_GRP_EN     7'h71
`define EPIU_IDX_GRP_FLAGS  7'h72
`define EPIU_IDX_CORE       7'h73

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define EPIU_ADDR_ENABLE    {`EPIU_IDX_ENABLE, 2'b00}
`define EPIU_ADDR_SENSE     {`EPIU_IDX_SENSE, 2'b00}
`define EPIU_ADDR_FLAGS     {`EPIU_IDX_FLAGS, 2'b00}
`define EPIU_ADDR_GRP_EN    {`EPIU_IDX_GRP_EN, 2'b00}
`define EPIU_ADDR_GRP_FLAGS {`EPIU_IDX_GRP_FLAGS, 2'b00}
`define EPIU_ADDR_MASK0     {`EPIU_IDX_MASK0, 2'b00}
`define EPIU_ADDR_MASK1     {`EPIU_IDX_MASK1, 2'b00}
`define EPIU_ADDR_MASK2     {`EPIU_IDX_MASK2, 2'b00}
`define EPIU_ADDR_CORE      {`EPIU_IDX_CORE, 2'b00}

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define EPIU_SENSE_W        4
`define EPIU_MASK1_W        7
`define EPIU_RESET_BYTE     8'h00
`define EPIU_GLOBAL_BIT     0

`endif

// ### hw/epiu_pkg.sv
package epiu_pkg;
    typedef enum logic [1:0] {
        EPIU_SENSE_LOW,
        EPIU_SENSE_ANY,
        EPIU_SENSE_FALL,
        EPIU_SENSE_RISE
    } epiu_sense_t;
    typedef logic [7:0]  epiu_byte_t;
    typedef logic [23:0] epiu_pins_t;
    typedef logic [4:0]  epiu_vec_t;
endpackage

// ### hw/epiu_top.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "epiu_consts.svh"

module epiu_top (
    // clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // axi4-lite write address
    input  wire logic [8:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    // axi4-lite write response
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // axi4-lite read address
    input  wire logic [8:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    // axi4-lite read data
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // pins (read back from pad even when driven as outputs)
    input  wire logic               ext_request_zero,
    input  wire logic               ext_request_one,
    input  wire epiu_pkg::epiu_pins_t pin_change_inputs,
    // core side
    input  wire logic               global_int_enable,
    input  wire epiu_pkg::epiu_vec_t vector_ack,
    output epiu_pkg::epiu_vec_t     vector_pending,
    output logic                    wake_request
);
    import epiu_pkg::*;

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [1:0]  ext_request_enable, next_ext_request_enable;
    logic [3:0]  ext_request_sense_control, next_ext_request_sense_control;
    logic [1:0]  ext_request_flags, next_ext_request_flags;
    logic [2:0]  pin_change_group_enable, next_pin_change_group_enable;
    logic [2:0]  group_flags, next_group_flags;
    epiu_byte_t  group0_pin_mask, next_group0_pin_mask;
    logic [6:0]  group1_pin_mask, next_group1_pin_mask;
    epiu_byte_t  group2_pin_mask, next_group2_pin_mask;

    // ----------------------------------------
    // pin synchronisers and sampled history
    // ----------------------------------------
    logic [25:0] sync_a, sync_b, sync_prev;
    logic [25:0] pin_now;

    assign pin_now = {ext_request_one, ext_request_zero, pin_change_inputs};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a    <= 26'h3ffffff;
            sync_b    <= 26'h3ffffff;
            sync_prev <= 26'h3ffffff;
        end else begin
            sync_a    <= pin_now;
            sync_b    <= sync_a;
            sync_prev <= sync_b;
        end
    end

    // ----------------------------------------
    // edge detection on dedicated pins
    // ----------------------------------------
    function automatic logic sense_hit(input logic [1:0] sel, input logic now, input logic prev);
        unique case (epiu_sense_t'(sel))
            EPIU_SENSE_LOW:  sense_hit = 1'b0;
            EPIU_SENSE_ANY:  sense_hit = now ^ prev;
            EPIU_SENSE_FALL: sense_hit = prev & ~now;
            EPIU_SENSE_RISE: sense_hit = now & ~prev;
        endcase
    endfunction

    logic [1:0] ext_hit, level_mode, live_low;
    logic [2:0] grp_hit;
    logic [23:0] pin_toggled, pin_armed;

    always_comb begin
        ext_hit[0]    = sense_hit(ext_request_sense_control[1:0], sync_b[24], sync_prev[24]);
        ext_hit[1]    = sense_hit(ext_request_sense_control[3:2], sync_b[25], sync_prev[25]);
        level_mode[0] = ext_request_sense_control[1:0] == 2'h0;
        level_mode[1] = ext_request_sense_control[3:2] == 2'h0;
        // live pin level, not the sampled one, so a stopped clock still wakes
        live_low[0]   = ~ext_request_zero;
        live_low[1]   = ~ext_request_one;
        pin_toggled   = sync_b[23:0] ^ sync_prev[23:0];
        pin_armed     = {group2_pin_mask & {8{pin_change_group_enable[2]}},
                         1'b0, group1_pin_mask & {7{pin_change_group_enable[1]}},
                         group0_pin_mask & {8{pin_change_group_enable[0]}}};
        grp_hit[0]    = |(pin_toggled[7:0] & pin_armed[7:0]);
        grp_hit[1]    = |(pin_toggled[14:8] & pin_armed[14:8]);
        grp_hit[2]    = |(pin_toggled[23:16] & pin_armed[23:16]);
    end

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    logic        aw_held, next_aw_held, w_held, next_w_held;
    logic [8:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic        w_lane0, next_w_lane0;
    logic        bvalid_q, next_bvalid_q;
    logic [1:0]  bresp_q, next_bresp_q;
    logic        rvalid_q, next_rvalid_q;
    logic [31:0] rdata_q, next_rdata_q;
    logic [1:0]  rresp_q, next_rresp_q;
    logic        do_write;
    logic [7:0]  wbyte;

    function automatic logic addr_known(input logic [8:0] a);
        unique case (a)
            `EPIU_ADDR_ENABLE, `EPIU_ADDR_SENSE, `EPIU_ADDR_FLAGS, `EPIU_ADDR_GRP_EN,
            `EPIU_ADDR_GRP_FLAGS, `EPIU_ADDR_MASK0, `EPIU_ADDR_MASK1,
            `EPIU_ADDR_MASK2, `EPIU_ADDR_CORE: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    endfunction

    assign s_axi_awready = ~aw_held & ~bvalid_q;
    assign s_axi_wready  = ~w_held & ~bvalid_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_lane0 = w_lane0;
        next_bvalid_q = bvalid_q;
        next_bresp_q = bresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held  = 1'b1;
            next_w_data  = s_axi_wdata;
            next_w_lane0 = s_axi_wstrb[0];
        end
        do_write = aw_held && w_held && !bvalid_q;
        wbyte    = w_data[7:0];
        if (do_write) begin
            next_aw_held  = 1'b0;
            next_w_held   = 1'b0;
            next_bvalid_q = 1'b1;
            next_bresp_q  = addr_known(aw_addr) ? 2'h0 : 2'h2;
        end else if (bvalid_q && s_axi_bready) begin
            next_bvalid_q = 1'b0;
        end
    end

    always_comb begin
        next_rvalid_q = rvalid_q;
        next_rdata_q  = rdata_q;
        next_rresp_q  = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid_q = 1'b1;
            next_rresp_q  = addr_known(s_axi_araddr) ? 2'h0 : 2'h2;
            unique case (s_axi_araddr)
                `EPIU_ADDR_ENABLE:    next_rdata_q = {30'h0, ext_request_enable};
                `EPIU_ADDR_SENSE:     next_rdata_q = {28'h0, ext_request_sense_control};
                `EPIU_ADDR_FLAGS:     next_rdata_q = {30'h0, ext_request_flags};
                `EPIU_ADDR_GRP_EN:    next_rdata_q = {29'h0, pin_change_group_enable};
                `EPIU_ADDR_GRP_FLAGS: next_rdata_q = {29'h0, group_flags};
                `EPIU_ADDR_MASK0:     next_rdata_q = {24'h0, group0_pin_mask};
                `EPIU_ADDR_MASK1:     next_rdata_q = {25'h0, group1_pin_mask};
                `EPIU_ADDR_MASK2:     next_rdata_q = {24'h0, group2_pin_mask};
                `EPIU_ADDR_CORE:      next_rdata_q = {31'h0, global_int_enable};
                default:              next_rdata_q = 32'h0;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            next_rvalid_q = 1'b0;
        end
    end

    // ----------------------------------------
    // control registers and flags
    // ----------------------------------------
    logic wr_en;

    always_comb begin
        wr_en = do_write && w_lane0;
        next_ext_request_enable        = ext_request_enable;
        next_ext_request_sense_control = ext_request_sense_control;
        next_pin_change_group_enable   = pin_change_group_enable;
        next_group0_pin_mask           = group0_pin_mask;
        next_group1_pin_mask           = group1_pin_mask;
        next_group2_pin_mask           = group2_pin_mask;
        next_ext_request_flags         = ext_request_flags;
        next_group_flags               = group_flags;
        if (wr_en) begin
            unique case (aw_addr)
                `EPIU_ADDR_ENABLE: next_ext_request_enable = wbyte[1:0];
                `EPIU_ADDR_SENSE:  next_ext_request_sense_control = wbyte[`EPIU_SENSE_W-1:0];
                `EPIU_ADDR_GRP_EN: next_pin_change_group_enable = wbyte[2:0];
                `EPIU_ADDR_MASK0:  next_group0_pin_mask = wbyte;
                `EPIU_ADDR_MASK1:  next_group1_pin_mask = wbyte[`EPIU_MASK1_W-1:0];
                `EPIU_ADDR_MASK2:  next_group2_pin_mask = wbyte;
                `EPIU_ADDR_FLAGS:  next_ext_request_flags = ext_request_flags & ~wbyte[1:0];
                `EPIU_ADDR_GRP_FLAGS: next_group_flags = group_flags & ~wbyte[2:0];
                default: ;
            endcase
        end
        next_ext_request_flags = next_ext_request_flags & ~vector_ack[1:0];
        next_group_flags       = next_group_flags & ~vector_ack[4:2];
        // set wins over any clear in the same cycle
        next_ext_request_flags = next_ext_request_flags | ext_hit;
        next_group_flags       = next_group_flags | grp_hit;
        next_ext_request_flags = next_ext_request_flags & ~level_mode;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_request_enable        <= 2'h0;
            ext_request_sense_control <= 4'h0;
            ext_request_flags         <= 2'h0;
            pin_change_group_enable   <= 3'h0;
            group_flags               <= 3'h0;
            group0_pin_mask           <= 8'h00;
            group1_pin_mask           <= 7'h00;
            group2_pin_mask           <= 8'h00;
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= 9'h000;
            w_data   <= 32'h0;
            w_lane0  <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= 2'h0;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= 2'h0;
        end else begin
            ext_request_enable        <= next_ext_request_enable;
            ext_request_sense_control <= next_ext_request_sense_control;
            ext_request_flags         <= next_ext_request_flags;
            pin_change_group_enable   <= next_pin_change_group_enable;
            group_flags               <= next_group_flags;
            group0_pin_mask           <= next_group0_pin_mask;
            group1_pin_mask           <= next_group1_pin_mask;
            group2_pin_mask           <= next_group2_pin_mask;
            aw_held  <= next_aw_held;
            w_held   <= next_w_held;
            aw_addr  <= next_aw_addr;
            w_data   <= next_w_data;
            w_lane0  <= next_w_lane0;
            bvalid_q <= next_bvalid_q;
            bresp_q  <= next_bresp_q;
            rvalid_q <= next_rvalid_q;
            rdata_q  <= next_rdata_q;
            rresp_q  <= next_rresp_q;
        end
    end

    // ----------------------------------------
    // pending requests, one per vector
    // ----------------------------------------
    logic [1:0] ext_src;

    always_comb begin
        // level request follows the pin, so a level gone early leaves nothing
        ext_src[0] = level_mode[0] ? live_low[0] : ext_request_flags[0];
        ext_src[1] = level_mode[1] ? live_low[1] : ext_request_flags[1];
        vector_pending[1:0] = ext_src & ext_request_enable & {2{global_int_enable}};
        vector_pending[4:2] = group_flags & pin_change_group_enable
                              & {3{global_int_enable}};
        // wake is independent of the clock: live low level or any armed pin mismatch
        wake_request = |(live_low & level_mode & ext_request_enable)
                     | |((pin_change_inputs ^ sync_b[23:0]) & pin_armed);
    end

endmodule

// ### bench/epiu_pin_model.sv
`timescale 1ns/1ps
// ----
// external pin sources
// ----
module epiu_pin_model
    import epiu_pkg::*;
(
    // clock
    input  wire logic          aclk,
    // wanted levels
    input  wire logic          want_zero,
    input  wire logic          want_one,
    input  wire epiu_pins_t    want_pc,
    // pins
    output logic               ext_request_zero,
    output logic               ext_request_one,
    output epiu_pins_t         pin_change_inputs
);
    initial begin
        ext_request_zero = 1'b1;
        ext_request_one = 1'b1;
        pin_change_inputs = '1;
    end
    // a level is held at least to the next edge
    always @(posedge aclk) begin
        ext_request_zero <= want_zero;
        ext_request_one <= want_one;
        pin_change_inputs <= want_pc;
    end
endmodule

// ### bench/epiu_top_props.sv
`timescale 1ns/1ps
// ----
// port checker
// ----
module epiu_top_props
    import epiu_pkg::*;
(
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // bus
    input  wire logic          s_axi_awvalid,
    input  wire logic          s_axi_awready,
    input  wire logic          s_axi_wvalid,
    input  wire logic          s_axi_wready,
    input  wire logic [1:0]    s_axi_bresp,
    input  wire logic          s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [8:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    input  wire logic          s_axi_arready,
    input  wire logic [31:0]   s_axi_rdata,
    input  wire logic [1:0]    s_axi_rresp,
    input  wire logic          s_axi_rvalid,
    input  wire logic          s_axi_rready,
    // core side
    input  wire logic          global_int_enable,
    input  wire epiu_vec_t     vector_pending
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    global_gate_a: assert property (!global_int_enable |-> vector_pending == 5'h00)
        else $error("pending with global bit low");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    ready_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response open");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 9'h1fc
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h00000000) else $error("unmapped read wrong");
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (vector_pending[0]);
    cover property (vector_pending[4]);
endmodule
bind epiu_top epiu_top_props chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .global_int_enable, .vector_pending);

// ### bench/external_pin_interrupt_unit_tb.sv
`timescale 1ns/1ps
`include "epiu_consts.svh"
// ----
// register and pin sequences
// ----
module external_pin_interrupt_unit_tb;
    import epiu_pkg::*;
    logic          aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [8:0]    s_axi_awaddr, s_axi_araddr;
    logic [31:0]   s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]    s_axi_wstrb;
    logic [1:0]    s_axi_bresp, s_axi_rresp, rsp, wrsp;
    logic          ext_request_zero, ext_request_one, want_zero, want_one, global_int_enable, wake_request;
    epiu_pins_t    pin_change_inputs, want_pc;
    epiu_vec_t     vector_ack, vector_pending;
    int            err_total, n_compared, cyc;
    logic [8:0]    at[8] = '{`EPIU_ADDR_ENABLE, `EPIU_ADDR_SENSE, `EPIU_ADDR_FLAGS, `EPIU_ADDR_GRP_EN,
                             `EPIU_ADDR_GRP_FLAGS, `EPIU_ADDR_MASK0, `EPIU_ADDR_MASK1, `EPIU_ADDR_MASK2};
    logic [31:0]   wx[8] = '{32'h3, 32'hf, 32'h0, 32'h7, 32'h0, 32'hff, 32'h7f, 32'hff};
    int            pcs[5] = '{1, 0, 8, 23, 0};
    logic [31:0]   gx[5] = '{32'h0, 32'h1, 32'h2, 32'h4, 32'h0};
    epiu_top dut_u (.*);
    epiu_pin_model pm_u (.aclk, .want_zero, .want_one, .want_pc, .ext_request_zero, .ext_request_one,
        .pin_change_inputs);
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        wrsp = s_axi_bresp;
    endtask
    task rdr(input logic [8:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask
    task drive(input int p, input logic v);
        if (p == 0) want_zero <= v;
        else want_one <= v;
    endtask
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test;
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, global_int_enable, vector_ack} = '0;
        {want_zero, want_one, want_pc, s_axi_wstrb} = '1;
        {err_total, n_compared, cyc} = '0;
        tick(5);
        aresetn <= 1'b1;
        foreach (at[i]) begin
            rdr(at[i]);
            chk("reset value", rd, 32'h0);
        end
        rdr(9'h1fc);
        chk("unmapped resp", 32'(rsp), 32'h2);
        chk("unmapped data", rd, 32'h0);
        wr(9'h1fc, 32'h0);
        chk("unmapped write", 32'(wrsp), 32'h2);
        foreach (at[i]) begin
            wr(at[i], 32'hffffffff);
            chk("write resp", 32'(wrsp), 32'h0);
            rdr(at[i]);
            chk("field width", rd, wx[i]);
        end
        wr(`EPIU_ADDR_SENSE, 32'h0);
        global_int_enable <= 1'b1;
        drive(0, 1'b0);
        tick(3);
        chk("level pending", 32'(vector_pending), 32'h1);
        chk("wake level", 32'(wake_request), 32'h1);
        rdr(`EPIU_ADDR_CORE);
        chk("core bit", rd, 32'h1);
        rdr(`EPIU_ADDR_FLAGS);
        chk("level flag", rd, 32'h0);
        global_int_enable <= 1'b0;
        tick(2);
        chk("global off", 32'(vector_pending), 32'h0);
        global_int_enable <= 1'b1;
        drive(0, 1'b1);
        tick(3);
        chk("level gone", 32'(vector_pending), 32'h0);
        chk("wake gone", 32'(wake_request), 32'h0);
        for (int p = 0; p < 2; p++) begin
            for (int m = 1; m < 4; m++) begin
                wr(`EPIU_ADDR_SENSE, 32'(m << (2 * p)));
                wr(`EPIU_ADDR_FLAGS, 32'h3);
                drive(p, 1'b0);
                tick(4);
                rdr(`EPIU_ADDR_FLAGS);
                chk("fall flag", rd, (m != 3) ? 32'(1 << p) : 32'h0);
                chk("fall pending", 32'(vector_pending), rd);
                wr(`EPIU_ADDR_FLAGS, 32'h0);
                rdr(`EPIU_ADDR_FLAGS);
                chk("zero write", rd, (m != 3) ? 32'(1 << p) : 32'h0);
                wr(`EPIU_ADDR_FLAGS, 32'h3);
                drive(p, 1'b1);
                tick(4);
                rdr(`EPIU_ADDR_FLAGS);
                chk("rise flag", rd, (m != 2) ? 32'(1 << p) : 32'h0);
                vector_ack <= epiu_vec_t'(1 << p);
                tick(1);
                vector_ack <= '0;
                rdr(`EPIU_ADDR_FLAGS);
                chk("ack clear", rd, 32'h0);
            end
        end
        wr(`EPIU_ADDR_MASK0, 32'h01);
        wr(`EPIU_ADDR_MASK1, 32'h01);
        wr(`EPIU_ADDR_MASK2, 32'h80);
        wr(`EPIU_ADDR_GRP_FLAGS, 32'h7);
        for (int i = 0; i < 5; i++) begin
            if (i == 4) wr(`EPIU_ADDR_GRP_EN, 32'h0);
            want_pc[pcs[i]] <= 1'b0;
            tick(5);
            rdr(`EPIU_ADDR_GRP_FLAGS);
            chk("group flag", rd, gx[i]);
            chk("group pending", 32'(vector_pending), gx[i] << 2);
            want_pc[pcs[i]] <= 1'b1;
            tick(5);
            vector_ack <= epiu_vec_t'(gx[i] << 2);
            tick(1);
            vector_ack <= '0;
            rdr(`EPIU_ADDR_GRP_FLAGS);
            chk("group ack", rd, 32'h0);
        end
        end_of_test;
    end
endmodule
